// ### design/sio_pkg.sv
// Purpose: shared constants for the serial port device and its far end
// Assumes: 10 MHz system clock, byte addressed register bus
// Notes:   register byte address is four times its index
package sio_pkg;
   localparam int          ADDR_W        = 8;
   // register indices and byte addresses
   localparam logic [7:0]  CTRL_IDX      = 8'h0a;
   localparam logic [7:0]  STAT_IDX      = 8'h0b;
   localparam logic [7:0]  DATA_IDX      = 8'h0c;
   localparam logic [7:0]  CTRL_ADDR     = {CTRL_IDX[5:0], 2'b00};
   localparam logic [7:0]  STAT_ADDR     = {STAT_IDX[5:0], 2'b00};
   localparam logic [7:0]  DATA_ADDR     = {DATA_IDX[5:0], 2'b00};
   // field positions and reset values
   localparam int          EN_BIT        = 6;
   localparam int          MS_BIT        = 4;
   localparam int          TCF_BIT       = 7;
   localparam int          COL_BIT       = 6;
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   // fallback port pin positions
   localparam int          PIN_SO        = 0;
   localparam int          PIN_SI        = 1;
   localparam int          PIN_SCK       = 2;
   // bus answers
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // timing
   localparam int          CLK_NS        = 100;
   localparam int          SCK_DIV       = 4;
   localparam int          STOP_OSC_CYC  = 4064;
   localparam int          OSC_PER_BUS   = 2;
   localparam int          STOP_REC_CYC  = (STOP_OSC_CYC + OSC_PER_BUS - 1) / OSC_PER_BUS;
   localparam int          REC_W         = 12;
   // decoded register select
   typedef enum logic [1:0] {SIO_SEL_CTRL, SIO_SEL_STAT, SIO_SEL_DATA, SIO_SEL_NONE} sio_sel_e;
endpackage : sio_pkg

// ### design/sio_link_if.sv
// Purpose: three wire serial link between the device and its far end
// Assumes: undriven lines idle high
// Notes:   device driver wins if both ends drive the clock line
`timescale 1ns/1ps
`default_nettype none
interface sio_link_if;
   logic dev_sck_o;
   logic dev_sck_oe;
   logic dev_so_o;
   logic dev_so_oe;
   logic dev_si_o;
   logic dev_si_oe;
   logic far_sck_o;
   logic far_sck_oe;
   logic far_so_o;
   logic far_so_oe;
   wire  sck_line;
   wire  d2f_line;
   wire  f2d_line;

   assign sck_line = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : 1'b1);
   assign d2f_line = dev_so_oe ? dev_so_o : 1'b1;
   assign f2d_line = dev_si_oe ? dev_si_o : (far_so_oe ? far_so_o : 1'b1);

   modport dev (output dev_sck_o, dev_sck_oe, dev_so_o, dev_so_oe, dev_si_o, dev_si_oe,
                input  sck_line, d2f_line, f2d_line);
   modport far (output far_sck_o, far_sck_oe, far_so_o, far_so_oe,
                input  sck_line, d2f_line);
endinterface : sio_link_if
`default_nettype wire

// ### design/sio_far.sv
// Purpose: far end serial port, master or slave, plain user side
// Assumes: same timing as the device end, link pins synchronised here
// Notes:   always enabled; mode follows MASTER
`timescale 1ns/1ps
`default_nettype none
module sio_far (
   // clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   // link
   sio_link_if.far          LINK,
   // user side
   input  wire logic        MASTER,
   input  wire logic        START,
   input  wire logic [7:0]  TX_DATA,
   output logic      [7:0]  RX_DATA,
   output logic             DONE,
   output logic             BUSY
);
   logic       sck_s1_r, sck_s2_r, sck_d_r, si_s1_r, si_s2_r;
   logic       busy_r, sck_r, so_r, done_r;
   logic [4:0] cnt_r;
   logic [7:0] sh_r;
   logic       rise, fall;

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         sck_s1_r <= 1'b1;
         sck_s2_r <= 1'b1;
         sck_d_r  <= 1'b1;
         si_s1_r  <= 1'b1;
         si_s2_r  <= 1'b1;
      end
      else
      begin
         sck_s1_r <= LINK.sck_line;
         sck_s2_r <= sck_s1_r;
         sck_d_r  <= sck_s2_r;
         si_s1_r  <= LINK.d2f_line;
         si_s2_r  <= si_s1_r;
      end
   end

   assign rise = sck_s2_r & ~sck_d_r;
   assign fall = ~sck_s2_r & sck_d_r;

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         busy_r <= 1'b0;
         cnt_r  <= 5'h00;
         sck_r  <= 1'b1;
         so_r   <= 1'b1;
         done_r <= 1'b0;
         sh_r   <= 8'h00;
      end
      else
      begin
         done_r <= 1'b0;
         if (START && !busy_r)
         begin
            sh_r <= TX_DATA;
            so_r <= TX_DATA[7];
         end
         if (MASTER)
         begin
            if (START && !busy_r)
            begin
               busy_r <= 1'b1;
               cnt_r  <= 5'h00;
               sck_r  <= 1'b0;
            end
            else if (busy_r)
            begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r[1:0] == 2'h1)
                  sck_r <= 1'b1;
               if (cnt_r[1:0] == 2'h3)
               begin
                  sh_r <= {sh_r[6:0], si_s2_r};
                  if (cnt_r == 5'h1f)
                  begin
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                  end
                  else
                  begin
                     sck_r <= 1'b0;
                     so_r  <= sh_r[6];
                  end
               end
            end
         end
         else
         begin
            sck_r <= 1'b1;
            if (fall && !busy_r)
            begin
               busy_r <= 1'b1;
               cnt_r  <= 5'h00;
            end
            else if (rise && busy_r)
            begin
               sh_r  <= {sh_r[6:0], si_s2_r};
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r[2:0] == 3'h7)
               begin
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
               end
               else
                  so_r <= sh_r[6];
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
         RX_DATA <= 8'h00;
      else if (done_r)
         RX_DATA <= sh_r;
   end

   assign DONE            = done_r;
   assign BUSY            = busy_r;
   assign LINK.far_sck_o  = sck_r;
   assign LINK.far_sck_oe = MASTER;
   assign LINK.far_so_o   = so_r;
   assign LINK.far_so_oe  = 1'b1;
endmodule : sio_far
`default_nettype wire

// ### design/sio_dev.sv
// Purpose: byte wide serial port with control, status and data registers
// Assumes: AXI4-Lite register access, link pins synchronised on CLK_SYS
// Notes:   master clock is CLK_SYS/4; halts during stop or wait
// Overview of operation
// R1: control register, enable bit6, master bit4
// R2: enable sets pin directions by mode
// R3: disable returns pins to port use
// R4: disable mid-transfer aborts and clears counter
// R5: master bit writable always, steers clock pin
// R6: complete flag on eighth rising clock edge
// R7: flag clears after status read, data access
// R8: data access during transfer sets collision
// R9: collision clears by same sequence, before next
// R10: without complete flag, toggle enable clears collision
// R11: single unbuffered data register, no reset
// R12: software touches data only while enabled
// R13: master data write starts transfer
// R14: stop halts port, long recovery afterwards
// R15: wait halts port, resumes at once
// R16: master halt leaves slave clocks alone; the code halts the slave shift engine too
// R17: clock idles high, fall starts, rise samples
// R18: master clock quarter rate, slave any slower
// R19: data-out holds last bit or preset
// R20: status bit7 complete, bit6 collision
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module sio_dev #(
   parameter int ADDR_W   = sio_pkg::ADDR_W,
   parameter int STOP_CYC = sio_pkg::STOP_REC_CYC
) (
   // clock and reset
   input  wire logic              CLK_SYS,
   input  wire logic              RST_N,
   // link
   sio_link_if.dev                LINK,
   // register bus
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   output logic      [1:0]        S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic      [31:0]       S_AXI_RDATA,
   output logic      [1:0]        S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   // general port fallback
   input  wire logic [2:0]        GPIO_DIR,
   input  wire logic [2:0]        GPIO_OUT,
   output logic      [2:0]        GPIO_IN,
   // low power
   input  wire logic              STOP_REQ,
   input  wire logic              WAIT_REQ,
   output logic                   HALTED
);
   logic                    aw_got_r, w_got_r, wlane_r, bvalid_r, rvalid_r;
   logic [ADDR_W-1:0]       awaddr_r;
   logic [7:0]              wdata_r, rdata_r;
   logic [1:0]              bresp_r, rresp_r;
   logic                    en_r, ms_r, tcf_r, col_r, seen_r;
   logic [sio_pkg::REC_W-1:0] rec_r;
   logic                    sck_s1_r, sck_s2_r, sck_d_r, si_s1_r, si_s2_r, so_s1_r, so_s2_r;
   logic                    busy_r, sck_r, so_r;
   logic [4:0]              cnt_r;
   logic [7:0]              sh_r;
   logic                    wr_do, ar_fire, wr_ctrl, wr_data, rd_stat, rd_data, data_acc;
   logic                    rise, fall, halted, xfer_done;
   sio_pkg::sio_sel_e       wsel, rsel;

   function automatic sio_pkg::sio_sel_e sio_dec(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(sio_pkg::CTRL_ADDR))
         return sio_pkg::SIO_SEL_CTRL;
      else if (a == ADDR_W'(sio_pkg::STAT_ADDR))
         return sio_pkg::SIO_SEL_STAT;
      else if (a == ADDR_W'(sio_pkg::DATA_ADDR))
         return sio_pkg::SIO_SEL_DATA;
      else
         return sio_pkg::SIO_SEL_NONE;
   endfunction : sio_dec

   // bus slave: address and data taken in either order
   assign S_AXI_AWREADY = ~aw_got_r & ~bvalid_r;
   assign S_AXI_WREADY  = ~w_got_r & ~bvalid_r;
   assign S_AXI_ARREADY = ~rvalid_r;
   assign wr_do         = aw_got_r & w_got_r & ~bvalid_r;
   assign ar_fire       = S_AXI_ARVALID & ~rvalid_r;
   assign wsel          = sio_dec(awaddr_r);
   assign rsel          = sio_dec(S_AXI_ARADDR);
   // writes without the low byte lane leave the registers alone
   assign wr_ctrl       = wr_do & wlane_r & (wsel == sio_pkg::SIO_SEL_CTRL);
   assign wr_data       = wr_do & wlane_r & (wsel == sio_pkg::SIO_SEL_DATA);
   assign rd_stat       = ar_fire & (rsel == sio_pkg::SIO_SEL_STAT);
   assign rd_data       = ar_fire & (rsel == sio_pkg::SIO_SEL_DATA);
   assign data_acc      = wr_data | rd_data;

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= 8'h00;
         wlane_r  <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r  <= sio_pkg::RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_got_r <= 1'b1;
            wdata_r <= S_AXI_WDATA[7:0];
            wlane_r <= S_AXI_WSTRB[0];
         end
         if (wr_do)
         begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= (wsel == sio_pkg::SIO_SEL_NONE) ? sio_pkg::RESP_SLVERR
                                                         : sio_pkg::RESP_OKAY;
         end
         else if (S_AXI_BREADY)
            bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 8'h00;
         rresp_r  <= sio_pkg::RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= sio_pkg::RESP_OKAY;
         unique case (rsel)
            sio_pkg::SIO_SEL_CTRL: rdata_r <= {1'b0, en_r, 1'b0, ms_r, 4'h0}; // [R1]
            sio_pkg::SIO_SEL_STAT: rdata_r <= {tcf_r, col_r, 6'h00};          // [R20]
            sio_pkg::SIO_SEL_DATA: rdata_r <= sh_r;                           // [R11]
            sio_pkg::SIO_SEL_NONE:
            begin
               rdata_r <= 8'h00;
               rresp_r <= sio_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (S_AXI_RREADY)
         rvalid_r <= 1'b0;
   end

   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP  = bresp_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RRESP  = rresp_r;
   assign S_AXI_RDATA  = {24'h000000, rdata_r};

   // control register
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         en_r <= sio_pkg::CTRL_RST[sio_pkg::EN_BIT];                 // [R1]
         ms_r <= sio_pkg::CTRL_RST[sio_pkg::MS_BIT];
      end
      else if (wr_ctrl)
      begin
         en_r <= wdata_r[sio_pkg::EN_BIT];
         ms_r <= wdata_r[sio_pkg::MS_BIT];                           // [R5]
      end
   end

   // stop recovery counted after stop ends; wait resumes at once
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
         rec_r <= '0;
      else if (STOP_REQ)
         rec_r <= sio_pkg::REC_W'(STOP_CYC);                         // [R14]
      else if (rec_r != '0)
         rec_r <= rec_r - sio_pkg::REC_W'(1);
   end

   assign halted = STOP_REQ | WAIT_REQ | (rec_r != '0);              // [R14] [R15]
   assign HALTED = halted;

   // pin synchronisers
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         sck_s1_r <= 1'b1;
         sck_s2_r <= 1'b1;
         sck_d_r  <= 1'b1;
         si_s1_r  <= 1'b1;
         si_s2_r  <= 1'b1;
         so_s1_r  <= 1'b1;
         so_s2_r  <= 1'b1;
      end
      else
      begin
         sck_s1_r <= LINK.sck_line;
         sck_s2_r <= sck_s1_r;
         sck_d_r  <= sck_s2_r;
         si_s1_r  <= LINK.f2d_line;
         si_s2_r  <= si_s1_r;
         so_s1_r  <= LINK.d2f_line;
         so_s2_r  <= so_s1_r;
      end
   end

   assign GPIO_IN = {sck_s2_r, si_s2_r, so_s2_r};
   assign rise    = sck_s2_r & ~sck_d_r;                             // [R17]
   assign fall    = ~sck_s2_r & sck_d_r;
   assign xfer_done = en_r & ~halted & busy_r &
                      (ms_r ? (cnt_r == 5'h1f) : (rise & (cnt_r[2:0] == 3'h7)));

   // shift engine; the master captures input two cycles after its own rise
   // so that the synchroniser delay and the far end's lag both fit
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         busy_r <= 1'b0;
         cnt_r  <= 5'h00;
         sck_r  <= 1'b1;
         so_r   <= 1'b0;
      end
      else if (!en_r)
      begin
         busy_r <= 1'b0;                                             // [R4]
         cnt_r  <= 5'h00;
         sck_r  <= 1'b1;
         so_r   <= GPIO_OUT[sio_pkg::PIN_SO];                        // [R19]
      end
      else if (!halted)
      begin
         if (wr_data)
            sh_r <= wdata_r;                                         // [R11]
         if (wr_data && !busy_r)
            so_r <= wdata_r[7];
         if (ms_r)
         begin
            if (wr_data && !busy_r)
            begin
               busy_r <= 1'b1;                                       // [R13]
               cnt_r  <= 5'h00;
               sck_r  <= 1'b0;                                       // [R17]
            end
            else if (busy_r)
            begin
               cnt_r <= cnt_r + 5'h01;                               // [R18]
               if (cnt_r[1:0] == 2'h1)
                  sck_r <= 1'b1;
               if (cnt_r[1:0] == 2'h3)
               begin
                  sh_r <= {sh_r[6:0], si_s2_r};
                  if (cnt_r == 5'h1f)
                     busy_r <= 1'b0;
                  else
                  begin
                     sck_r <= 1'b0;
                     so_r  <= sh_r[6];
                  end
               end
            end
         end
         else
         begin
            sck_r <= 1'b1;
            if (fall && !busy_r)
            begin
               busy_r <= 1'b1;                                       // [R17]
               cnt_r  <= 5'h00;
            end
            else if (rise && busy_r)
            begin
               sh_r  <= {sh_r[6:0], si_s2_r};                        // [R18]
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r[2:0] == 3'h7)
                  busy_r <= 1'b0;
               else
                  so_r <= sh_r[6];                                   // [R19]
            end
         end
      end
   end

   // status flags: a setting event wins over a clear in the same cycle
   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         tcf_r  <= 1'b0;
         col_r  <= 1'b0;
         seen_r <= 1'b0;
      end
      else
      begin
         if (xfer_done)
            tcf_r <= 1'b1;                                           // [R6]
         else if (data_acc && seen_r)
            tcf_r <= 1'b0;                                           // [R7]
         if (rd_stat)
            seen_r <= tcf_r;
         else if (data_acc)
            seen_r <= 1'b0;
         if (data_acc && busy_r)
            col_r <= 1'b1;                                           // [R8]
         else if (data_acc && seen_r)
            col_r <= 1'b0;                                           // [R9]
         else if (wr_ctrl && wdata_r[sio_pkg::EN_BIT] && !en_r && !tcf_r)
            col_r <= 1'b0;                                           // [R10]
      end
   end

   // pin ownership; slave clock comes only from the far end
   assign LINK.dev_sck_oe = en_r ? ms_r : GPIO_DIR[sio_pkg::PIN_SCK];  // [R2] [R5] [R16]
   assign LINK.dev_sck_o  = en_r ? sck_r : GPIO_OUT[sio_pkg::PIN_SCK]; // [R3]
   assign LINK.dev_so_oe  = en_r | GPIO_DIR[sio_pkg::PIN_SO];
   assign LINK.dev_so_o   = en_r ? so_r : GPIO_OUT[sio_pkg::PIN_SO];
   assign LINK.dev_si_oe  = ~en_r & GPIO_DIR[sio_pkg::PIN_SI];         // [R2] [R3]
   assign LINK.dev_si_o   = GPIO_OUT[sio_pkg::PIN_SI];
endmodule : sio_dev
`default_nettype wire

// ### sim/sio_link_props.sv
// Purpose: link checker for the device and far end pair
// Assumes: both ends joined by one link interface
// Notes:   sees interface wires only, no register state
`timescale 1ns/1ps
`default_nettype none
module sio_link_props (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // device end
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe,
   input wire logic dev_so_o,
   input wire logic dev_so_oe,
   input wire logic dev_si_oe,
   // far end
   input wire logic far_sck_o,
   input wire logic far_sck_oe,
   input wire logic far_so_o
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // a start fall follows at least three high samples, a mid-byte fall only two
   sequence m_start;
      dev_sck_oe && $fell(dev_sck_o) && $past(dev_sck_o, 3);
   endsequence
   sequence f_start;
      far_sck_oe && $fell(far_sck_o) && $past(far_sck_o, 3);
   endsequence
   chk_sck_quarter: assert property (
      dev_sck_oe && $rose(dev_sck_o) |-> !$past(dev_sck_o, 2) && $past(dev_sck_o, 3))
      else $error("master clock not at quarter rate");
   chk_byte_length: assert property (disable iff (!RST_N || !dev_sck_oe)
      m_start |-> ##29 !dev_sck_o ##1 dev_sck_o[*3])
      else $error("master byte not eight clocks");
   chk_so_driven: assert property (m_start |-> dev_so_oe)
      else $error("data out not driven in transfer");
   chk_si_released: assert property (dev_so_oe && dev_sck_oe |-> !dev_si_oe)
      else $error("data in pin driven");
   chk_so_on_fall: assert property (
      dev_sck_oe && $past(dev_sck_oe) && dev_so_oe && $past(dev_so_oe)
      && $changed(dev_so_o) |-> $fell(dev_sck_o))
      else $error("data out moved off a falling clock");
   chk_far_quarter: assert property (
      far_sck_oe && $rose(far_sck_o) |-> !$past(far_sck_o, 2) && $past(far_sck_o, 3))
      else $error("far clock not at quarter rate");
   chk_far_length: assert property (disable iff (!RST_N || !far_sck_oe)
      f_start |-> ##29 !far_sck_o ##1 far_sck_o[*3])
      else $error("far byte not eight clocks");
   chk_far_so_fall: assert property (
      far_sck_oe && $past(far_sck_oe) && $changed(far_so_o) |-> $fell(far_sck_o))
      else $error("far data moved off a falling clock");
   cover property (m_start);
   cover property (f_start);
   cover property ($fell(dev_sck_oe));
endmodule : sio_link_props
`default_nettype wire

// ### sim/sio_dev_tb.sv
// Purpose: register level test of the serial port against its far end
// Assumes: far end from the same design, joined by the link interface
// Notes:   stop recovery shortened to eight cycles
`timescale 1ns/1ps
`default_nettype none
module sio_dev_tb;
   localparam int         REC = 8;
   localparam logic [7:0] CA  = sio_pkg::CTRL_ADDR;
   localparam logic [7:0] SA  = sio_pkg::STAT_ADDR;
   localparam logic [7:0] DA  = sio_pkg::DATA_ADDR;
   localparam logic [7:0] EN  = 8'h01 << sio_pkg::EN_BIT;
   localparam logic [7:0] MS  = 8'h01 << sio_pkg::MS_BIT;
   localparam logic [7:0] TCF = 8'h01 << sio_pkg::TCF_BIT;
   localparam logic [7:0] COL = 8'h01 << sio_pkg::COL_BIT;
   logic        CLK_SYS, RST_N, STOP_REQ, WAIT_REQ, HALTED, MASTER, START, DONE, BUSY;
   logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   logic        S_AXI_RVALID, S_AXI_RREADY;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, TX_DATA, RX_DATA;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdat;
   logic [3:0]  S_AXI_WSTRB;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, resp;
   logic [2:0]  GPIO_DIR, GPIO_OUT, GPIO_IN;
   int          errors, samples_checked;

   sio_link_if i_sio_link_if ();
   sio_dev #(.STOP_CYC(REC)) i_sio_dev (.LINK(i_sio_link_if), .*);
   sio_far i_sio_far (.LINK(i_sio_link_if), .*);
   sio_link_props i_sio_link_props (
      .CLK_SYS    (CLK_SYS),
      .RST_N      (RST_N),
      .dev_sck_o  (i_sio_link_if.dev_sck_o),
      .dev_sck_oe (i_sio_link_if.dev_sck_oe),
      .dev_so_o   (i_sio_link_if.dev_so_o),
      .dev_so_oe  (i_sio_link_if.dev_so_oe),
      .dev_si_oe  (i_sio_link_if.dev_si_oe),
      .far_sck_o  (i_sio_link_if.far_sck_o),
      .far_sck_oe (i_sio_link_if.far_sck_oe),
      .far_so_o   (i_sio_link_if.far_so_o)
   );

   initial
   begin
      CLK_SYS = 1'b0;
      forever #50 CLK_SYS = ~CLK_SYS;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic cyc(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask : cyc

   // address and data offered together, each dropped at its own ready
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h0, d};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      while (aw || w)
      begin
         @(posedge CLK_SYS);
         if (S_AXI_AWREADY === 1'b1) aw = 1'b0;
         if (S_AXI_WREADY === 1'b1) w = 1'b0;
         S_AXI_AWVALID <= aw;
         S_AXI_WVALID <= w;
      end
      do @(posedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
      resp = S_AXI_BRESP;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 1'b0;
      do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
      rdat = S_AXI_RDATA;
      resp = S_AXI_RRESP;
   endtask : rd

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      check(rdat, {24'h0, e});
   endtask : rdc

   task automatic far_go(input logic [7:0] d);
      TX_DATA <= d;
      START <= 1'b1;
      @(posedge CLK_SYS);
      START <= 1'b0;
   endtask : far_go

   initial
   begin
      #400000;
      errors++;
      tally_and_finish;
   end

   initial
   begin
      {RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, STOP_REQ, WAIT_REQ} = '0;
      {MASTER, START, TX_DATA, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
      {S_AXI_BREADY, S_AXI_RREADY, S_AXI_WSTRB} = 6'h31;
      GPIO_DIR = 3'b000;
      GPIO_OUT = 3'b100;
      errors = 0;
      samples_checked = 0;
      cyc(2);
      RST_N <= 1'b1;
      cyc(1);
      rdc(CA, 8'h00);
      rdc(SA, 8'h00);
      wr(CA, 8'hff);
      rdc(CA, EN | MS);
      check(32'(i_sio_link_if.d2f_line), 32'h0);
      wr(CA, MS);
      rdc(CA, MS);
      check(32'(i_sio_link_if.dev_sck_oe), 32'h0);
      wr(CA, EN | MS);
      cyc(3);
      check(32'({i_sio_link_if.dev_sck_oe, i_sio_link_if.dev_so_oe,
                 i_sio_link_if.dev_si_oe}), 32'h6);
      wr(CA, EN);
      cyc(3);
      check(32'(i_sio_link_if.dev_sck_oe), 32'h0);
      // master exchange with the far end as slave
      wr(CA, EN | MS);
      far_go(8'h3c);
      wr(DA, 8'ha5);
      do @(posedge CLK_SYS); while (DONE !== 1'b1);
      check(32'({DONE, BUSY}), 32'h2);
      rdc(DA, 8'h3c);
      rdc(SA, TCF);
      check(32'(RX_DATA), 32'ha5);
      far_go(8'h81);
      wr(DA, 8'h7e);
      cyc(40);
      check(32'(RX_DATA), 32'h7e);
      check(32'(i_sio_link_if.d2f_line), 32'h0);
      rdc(SA, TCF);
      rdc(DA, 8'h81);
      rdc(SA, 8'h00);
      wr(SA, 8'hff);
      rdc(SA, 8'h00);
      // slave mode, data written while the far master shifts
      wr(CA, EN);
      wr(DA, 8'h96);
      MASTER <= 1'b1;
      cyc(2);
      far_go(8'h5a);
      cyc(8);
      wr(DA, 8'h96);
      cyc(40);
      rdc(SA, TCF | COL);
      rd(DA);
      rdc(SA, 8'h00);
      // collision then abort; far slave left mid-byte, so the next transfer checks only the complete flag
      MASTER <= 1'b0;
      wr(CA, EN | MS);
      wr(DA, 8'h0f);
      cyc(6);
      rd(DA);
      wr(CA, MS);
      rdc(SA, COL);
      check(32'(i_sio_link_if.dev_sck_oe), 32'h0);
      wr(CA, EN | MS);
      rdc(SA, 8'h00);
      wr(DA, 8'h33);
      cyc(40);
      rdc(SA, TCF);
      // pins back in port use while disabled
      wr(CA, 8'h00);
      GPIO_OUT <= 3'b100;
      cyc(2);
      GPIO_DIR <= 3'b101;
      cyc(4);
      check(32'({i_sio_link_if.sck_line, i_sio_link_if.d2f_line}), 32'h2);
      check(32'(GPIO_IN & 3'b101), 32'h4);
      GPIO_DIR <= 3'b000;
      GPIO_OUT <= 3'b101;
      STOP_REQ <= 1'b1;
      cyc(2);
      check(32'(HALTED), 32'h1);
      STOP_REQ <= 1'b0;
      cyc(2);
      check(32'(HALTED), 32'h1);
      cyc(REC + 2);
      check(32'(HALTED), 32'h0);
      WAIT_REQ <= 1'b1;
      cyc(2);
      check(32'(HALTED), 32'h1);
      WAIT_REQ <= 1'b0;
      cyc(1);
      check(32'(HALTED), 32'h0);
      wr(8'h00, 8'h55);
      check(32'(resp), 32'(sio_pkg::RESP_SLVERR));
      rd(8'h34);
      check({rdat[29:0], resp}, 32'(sio_pkg::RESP_SLVERR));
      tally_and_finish;
   end
endmodule : sio_dev_tb
`default_nettype wire
